// file: design/pdc_channel_config.sv
// Playback DSP channel configuration: three control registers and the
// applied filter, volume and channel power settings derived from them.
// Assumes a byte-wide register port from the control interface decoder,
// a one-cycle sample strobe, and the master power bit kept elsewhere.
`timescale 1ns/1ns

module pdc_channel_config (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    // Register port
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    input  wire logic [7:0]            regAddr,
    input  wire logic [7:0]            regWrData,
    output logic      [7:0]            regRdData,
    output logic                       regRdValid,
    // Datapath timing and outside state
    input  wire logic                  sampleStrobe,
    input  wire logic                  playbackMasterPower,
    input  wire logic                  customCoefLoaded,
    input  wire pdc_pkg::pdc_vol_vec_t digitalVolume,
    // Applied filter settings
    output pdc_pkg::pdc_dsp_cfg_t      dspCfg,
    output logic                       customIirOn,
    output logic                       customIirAllPass,
    output logic                       biquadsBypassed,
    // Applied volume per channel, index 3 is channel one
    output pdc_pkg::pdc_vol_vec_t      appliedVolume,
    output logic      [3:0]            chanMuted,
    // Channel power, bit 3 is channel one
    output logic      [3:0]            chanPowered,
    output logic                       powerChangeRefused
);

    // Software-visible registers
    logic [7:0] filterChainConfig_reg;
    logic [7:0] outputChannelEnable_reg;
    logic [7:0] livePowerSwitchConfig_reg;
    logic [7:0] regRdData_reg;
    logic       regRdValid_reg;

    // Write strobes, one per register
    logic       wrFilterChain;
    logic       wrChanEnable;
    logic       wrLivePower;

    // Applied state
    pdc_pkg::pdc_dsp_cfg_t dspCfgNext;
    pdc_pkg::pdc_dsp_cfg_t dspCfgApplied;
    pdc_pkg::pdc_vol_vec_t appliedVolume_reg;
    pdc_pkg::pdc_vol_vec_t appliedVolume_next;
    logic [3:0]            chanPowered_reg;
    logic [3:0]            chanPowered_next;
    logic                  refused_reg;
    logic                  refused_next;
    logic [3:0]            powerTarget;
    logic [3:0]            chanEnables;
    logic                  liveSwitchOn;
    logic                  liveChanLimit;
    logic                  customIirOn_reg;
    logic                  biquadsBypassed_reg;
    logic [3:0]            chanMuted_reg;
    logic [3:0]            chanMuted_next;

    // Address hit test, shared by the write and read paths
    function automatic logic addrHit(input logic [7:0] a, input logic [7:0] offs);
        addrHit = (a == offs);
    endfunction

    // Reserved interpolation code keeps the previous response
    function automatic pdc_pkg::pdc_interp_t interpPick(
        input logic [1:0]          code,
        input pdc_pkg::pdc_interp_t prev
    );
        if (code == pdc_pkg::PDC_INTERP_RESERVED) begin
            interpPick = prev;
        end else begin
            interpPick = pdc_pkg::pdc_interp_t'(code);
        end
    endfunction

    // Zero code on the high-pass select means the custom IIR stage
    function automatic logic hpfIsCustom(input pdc_pkg::pdc_hpf_t sel);
        hpfIsCustom = (sel == pdc_pkg::PDC_HPF_CUSTOM_IIR);
    endfunction

    // A zero count switches every biquad off
    function automatic logic noBiquads(input logic [1:0] count);
        noBiquads = (count == 2'h0);
    endfunction

    // Zero volume code is mute
    function automatic logic isMuteCode(input logic [7:0] code);
        isMuteCode = (code == pdc_pkg::VOLUME_MUTE_CODE);
    endfunction

    // One address decode per register, shared by its write process
    assign wrFilterChain = regWrEn && addrHit(regAddr, pdc_pkg::FILTER_CHAIN_CONFIG_ADDR);
    assign wrChanEnable  = regWrEn && addrHit(regAddr, pdc_pkg::OUTPUT_CHANNEL_ENABLE_ADDR);
    assign wrLivePower   = regWrEn && addrHit(regAddr, pdc_pkg::LIVE_POWER_SWITCH_CONFIG_ADDR);

    // Filter chain register, fully read/write
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            filterChainConfig_reg <= pdc_pkg::FILTER_CHAIN_CONFIG_RST;
        end else if (wrFilterChain) begin
            filterChainConfig_reg <= regWrData;
        end
    end

    // Channel enable register; reserved bits stored as written
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            outputChannelEnable_reg <= pdc_pkg::OUTPUT_CHANNEL_ENABLE_RST;
        end else if (wrChanEnable) begin
            // Upper bits rely on software writing their reset values
            outputChannelEnable_reg <= regWrData;
        end
    end

    // Live power register; low three bits hard zero
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            livePowerSwitchConfig_reg <= pdc_pkg::LIVE_POWER_SWITCH_CONFIG_RST;
        end else if (wrLivePower) begin
            livePowerSwitchConfig_reg <= regWrData & pdc_pkg::LIVE_WRITE_MASK;
        end
    end

    // Registered read data, valid one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            regRdData_reg  <= pdc_pkg::UNMAPPED_READ_VALUE;
            regRdValid_reg <= 1'b0;
        end else begin
            regRdValid_reg <= regRdEn;
            if (regRdEn) begin
                if (addrHit(regAddr, pdc_pkg::FILTER_CHAIN_CONFIG_ADDR)) begin
                    regRdData_reg <= filterChainConfig_reg;
                end else if (addrHit(regAddr, pdc_pkg::OUTPUT_CHANNEL_ENABLE_ADDR)) begin
                    regRdData_reg <= outputChannelEnable_reg;
                end else if (addrHit(regAddr, pdc_pkg::LIVE_POWER_SWITCH_CONFIG_ADDR)) begin
                    regRdData_reg <= livePowerSwitchConfig_reg;
                end else begin
                    regRdData_reg <= pdc_pkg::UNMAPPED_READ_VALUE;
                end
            end
        end
    end

    assign regRdData  = regRdData_reg;
    assign regRdValid = regRdValid_reg;

    // Decode the filter register into the applied form
    always_comb begin
        dspCfgNext.interpResponseSel = interpPick(
            filterChainConfig_reg[pdc_pkg::INTERP_MSB:pdc_pkg::INTERP_LSB],
            dspCfgApplied.interpResponseSel);
        dspCfgNext.highpassCornerSel = pdc_pkg::pdc_hpf_t'(
            filterChainConfig_reg[pdc_pkg::HPF_MSB:pdc_pkg::HPF_LSB]);
        dspCfgNext.biquadStageCount  =
            filterChainConfig_reg[pdc_pkg::BIQUAD_MSB:pdc_pkg::BIQUAD_LSB];
        dspCfgNext.softStepOn        = ~filterChainConfig_reg[pdc_pkg::SOFT_STEP_BIT];
        dspCfgNext.volumeSharedMode  = filterChainConfig_reg[pdc_pkg::GANG_BIT];
    end

    // Filter settings cross into the datapath only at a sample boundary
    pdc_sample_latch #(
        .WIDTH     ($bits(pdc_pkg::pdc_dsp_cfg_t)),
        .RESET_VAL (pdc_pkg::DSP_CFG_RST)
    ) u_dsp_latch (
        .clk_sys      (clk_sys),
        .rst_b        (rst_b),
        .sampleStrobe (sampleStrobe),
        .dIn          (dspCfgNext),
        .dOut         (dspCfgApplied)
    );

    assign dspCfg = dspCfgApplied;

    // Flags latch with the settings they describe, so a flag never
    // disagrees with the field beside it
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            customIirOn_reg     <= hpfIsCustom(pdc_pkg::DSP_CFG_RST.highpassCornerSel);
            biquadsBypassed_reg <= noBiquads(pdc_pkg::DSP_CFG_RST.biquadStageCount);
        end else if (sampleStrobe) begin
            customIirOn_reg     <= hpfIsCustom(dspCfgNext.highpassCornerSel);
            biquadsBypassed_reg <= noBiquads(dspCfgNext.biquadStageCount);
        end
    end

    // Custom IIR stays all-pass until the coefficient store is loaded
    assign customIirOn      = customIirOn_reg;
    assign customIirAllPass = customIirOn_reg && !customCoefLoaded;
    assign biquadsBypassed  = biquadsBypassed_reg;

    // Volume selection; ganging copies channel one even when it is off
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (dspCfgNext.volumeSharedMode) begin
                appliedVolume_next[i] = digitalVolume[3];
            end else begin
                appliedVolume_next[i] = digitalVolume[i];
            end
        end
    end

    // Volume codes move with the sample boundary too
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            appliedVolume_reg <= {4{pdc_pkg::VOLUME_ZERO_DB}};
        end else if (sampleStrobe) begin
            appliedVolume_reg <= appliedVolume_next;
        end
    end

    assign appliedVolume = appliedVolume_reg;

    // Code zero is mute, judged on the codes about to be applied
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chanMuted_next[i] = isMuteCode(appliedVolume_next[i]);
        end
    end

    // Mute flags move with the volume codes they come from
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            chanMuted_reg <= {4{isMuteCode(pdc_pkg::VOLUME_ZERO_DB)}};
        end else if (sampleStrobe) begin
            chanMuted_reg <= chanMuted_next;
        end
    end

    assign chanMuted = chanMuted_reg;

    // Power target from master bit, enables and the live channel limit
    assign chanEnables   = outputChannelEnable_reg[pdc_pkg::CHAN_EN_MSB:pdc_pkg::CHAN_EN_LSB];
    assign liveSwitchOn  = livePowerSwitchConfig_reg[pdc_pkg::LIVE_ON_BIT];
    assign liveChanLimit = livePowerSwitchConfig_reg[pdc_pkg::LIVE_LIMIT_BIT];

    always_comb begin
        if (!playbackMasterPower) begin
            powerTarget = pdc_pkg::CHAN_NONE;
        end else if (liveSwitchOn && !liveChanLimit) begin
            powerTarget = chanEnables & pdc_pkg::CHAN_ONE_TWO_MASK;
        end else begin
            powerTarget = chanEnables & pdc_pkg::CHAN_ALL_MASK;
        end
    end

    // Without live switching the running set is frozen until all stop
    always_comb begin
        refused_next     = 1'b0;
        chanPowered_next = powerTarget;
        if (!playbackMasterPower) begin
            chanPowered_next = pdc_pkg::CHAN_NONE;
        end else if (!liveSwitchOn && (chanPowered_reg != pdc_pkg::CHAN_NONE)) begin
            chanPowered_next = chanPowered_reg;
            refused_next     = (powerTarget != chanPowered_reg);
        end
    end

    // Power state steps at sample boundaries so a channel never starts mid-sample
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            chanPowered_reg <= pdc_pkg::CHAN_NONE;
            refused_reg     <= 1'b0;
        end else if (sampleStrobe) begin
            chanPowered_reg <= chanPowered_next;
            refused_reg     <= refused_next;
        end
    end

    assign chanPowered        = chanPowered_reg;
    assign powerChangeRefused = refused_reg;

endmodule

// file: design/pdc_pkg.sv
// Package for the playback DSP channel configuration block.
// Assumes one byte-wide register port and a single 50 MHz clock domain.
package pdc_pkg;

    // Register offsets on the control port
    localparam logic [7:0] FILTER_CHAIN_CONFIG_ADDR      = 8'h73;
    localparam logic [7:0] OUTPUT_CHANNEL_ENABLE_ADDR    = 8'h76;
    localparam logic [7:0] LIVE_POWER_SWITCH_CONFIG_ADDR = 8'h77;

    // Reset values
    localparam logic [7:0] FILTER_CHAIN_CONFIG_RST      = 8'h18;
    localparam logic [7:0] OUTPUT_CHANNEL_ENABLE_RST    = 8'hCC;
    localparam logic [7:0] LIVE_POWER_SWITCH_CONFIG_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE          = 8'h00;

    // Field positions, filter chain config
    localparam int INTERP_MSB     = 7;
    localparam int INTERP_LSB     = 6;
    localparam int HPF_MSB        = 5;
    localparam int HPF_LSB        = 4;
    localparam int BIQUAD_MSB     = 3;
    localparam int BIQUAD_LSB     = 2;
    localparam int SOFT_STEP_BIT  = 1;
    localparam int GANG_BIT       = 0;

    // Field positions, channel enable (bit 3 is channel one)
    localparam int CHAN_EN_MSB    = 3;
    localparam int CHAN_EN_LSB    = 0;

    // Field positions, live power switch config
    localparam int LIVE_ON_BIT    = 5;
    localparam int LIVE_LIMIT_BIT = 4;
    // Writable bits of live power config: 7, 6, 5, 4, 3; bits 2-0 read zero
    localparam logic [7:0] LIVE_WRITE_MASK = 8'hF8;

    // Channel masks, bit 3 is channel one
    localparam logic [3:0] CHAN_ONE_TWO_MASK = 4'hC;
    localparam logic [3:0] CHAN_ALL_MASK     = 4'hF;
    localparam logic [3:0] CHAN_NONE         = 4'h0;

    // Volume codes
    localparam logic [7:0] VOLUME_MUTE_CODE  = 8'h00;
    localparam logic [7:0] VOLUME_ZERO_DB    = 8'hC9;

    typedef enum logic [1:0] {
        PDC_INTERP_LINEAR   = 2'h0,
        PDC_INTERP_LOW_LAT  = 2'h1,
        PDC_INTERP_ULTRA    = 2'h2,
        PDC_INTERP_RESERVED = 2'h3
    } pdc_interp_t;

    typedef enum logic [1:0] {
        PDC_HPF_CUSTOM_IIR  = 2'h0,
        PDC_HPF_CORNER_LOW  = 2'h1,
        PDC_HPF_CORNER_MID  = 2'h2,
        PDC_HPF_CORNER_HIGH = 2'h3
    } pdc_hpf_t;

    // Applied filter settings handed to the datapath
    typedef struct packed {
        pdc_interp_t interpResponseSel;
        pdc_hpf_t    highpassCornerSel;
        logic [1:0]  biquadStageCount;
        logic        softStepOn;
        logic        volumeSharedMode;
    } pdc_dsp_cfg_t;

    localparam pdc_dsp_cfg_t DSP_CFG_RST = '{
        interpResponseSel: PDC_INTERP_LINEAR,
        highpassCornerSel: PDC_HPF_CORNER_LOW,
        biquadStageCount:  2'h2,
        softStepOn:        1'b1,
        volumeSharedMode:  1'b0
    };

    // Four volume codes, index 3 is channel one
    typedef logic [3:0][7:0] pdc_vol_vec_t;

endpackage

// file: design/pdc_sample_latch.sv
// Holding register that takes a new value only at a sample boundary.
// Assumes the strobe is a one-cycle pulse in the clk_sys domain.
`timescale 1ns/1ns

module pdc_sample_latch #(
    parameter int              WIDTH     = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // Boundary strobe and data
    input  wire logic             sampleStrobe,
    input  wire logic [WIDTH-1:0] dIn,
    output logic      [WIDTH-1:0] dOut
);

    logic [WIDTH-1:0] hold_reg;

    // Whole word moves at once, so the datapath never sees a half update
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hold_reg <= RESET_VAL;
        end else if (sampleStrobe) begin
            hold_reg <= dIn;
        end
    end

    assign dOut = hold_reg;

endmodule

// file: sim/pdc_channel_config_sva.sv
// Checker for the playback DSP channel configuration block.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/1ns

module pdc_channel_config_sva (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst_b,
    // Register port
    input wire logic                  regWrEn,
    input wire logic                  regRdEn,
    input wire logic [7:0]            regAddr,
    input wire logic [7:0]            regWrData,
    input wire logic [7:0]            regRdData,
    input wire logic                  regRdValid,
    // Timing and outside state
    input wire logic                  sampleStrobe,
    input wire logic                  playbackMasterPower,
    input wire logic                  customCoefLoaded,
    input wire pdc_pkg::pdc_vol_vec_t digitalVolume,
    // Applied settings
    input wire pdc_pkg::pdc_dsp_cfg_t dspCfg,
    input wire logic                  customIirOn,
    input wire logic                  customIirAllPass,
    input wire logic                  biquadsBypassed,
    input wire pdc_pkg::pdc_vol_vec_t appliedVolume,
    input wire logic [3:0]            chanMuted,
    input wire logic [3:0]            chanPowered,
    input wire logic                  powerChangeRefused
);
    // One domain, so clock and disable are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Steps the properties use; s_read and s_strobe are each shared by two
    sequence s_read;   regRdEn;       endsequence
    sequence s_strobe; sampleStrobe;  endsequence
    sequence s_quiet;  !sampleStrobe; endsequence

    a_read_answered: assert property (s_read |=> regRdValid)
        else $error("read not answered");
    a_valid_pulse: assert property (!regRdEn |=> !regRdValid)
        else $error("valid without read");
    a_unmapped_zero: assert property (regRdEn
        && !(regAddr inside {8'h73, 8'h76, 8'h77}) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_live_low_zero: assert property (s_read ##0 regAddr == 8'h77
        |=> regRdData[2:0] == 3'h0) else $error("reserved low bits not zero");
    // Partial updates would reach the datapath mid-sample
    a_hold_settings: assert property (s_quiet |=> $stable(dspCfg)
        && $stable(appliedVolume) && $stable(chanPowered)) else $error("change off boundary");
    a_interp_legal: assert property (dspCfg.interpResponseSel != 2'h3)
        else $error("reserved interpolation applied");
    a_iir_select: assert property (customIirOn == (dspCfg.highpassCornerSel == 2'h0)
        && customIirAllPass == (customIirOn && !customCoefLoaded)) else $error("iir select");
    a_bq_bypass: assert property (biquadsBypassed == (dspCfg.biquadStageCount == 2'h0))
        else $error("biquad bypass wrong");
    a_mute_flags: assert property (chanMuted == {appliedVolume[3] == 8'h00,
        appliedVolume[2] == 8'h00, appliedVolume[1] == 8'h00, appliedVolume[0] == 8'h00})
        else $error("mute flags wrong");
    a_gang_volume: assert property (s_strobe |=> !dspCfg.volumeSharedMode
        || appliedVolume == {4{$past(digitalVolume[3])}}) else $error("gang volume wrong");
    a_master_off: assert property (s_strobe ##0 !playbackMasterPower
        |=> chanPowered == 4'h0) else $error("channels on without master");
endmodule

bind pdc_channel_config pdc_channel_config_sva chk_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .sampleStrobe(sampleStrobe),
    .playbackMasterPower(playbackMasterPower), .customCoefLoaded(customCoefLoaded),
    .digitalVolume(digitalVolume), .dspCfg(dspCfg), .customIirOn(customIirOn),
    .customIirAllPass(customIirAllPass), .biquadsBypassed(biquadsBypassed),
    .appliedVolume(appliedVolume), .chanMuted(chanMuted), .chanPowered(chanPowered),
    .powerChangeRefused(powerChangeRefused));

// file: sim/pdc_channel_config_test.sv
// Self-checking bench for the channel configuration block.
// Drives every input while the clock is low; the checker is bound separately.
`timescale 1ns/1ns

module pdc_channel_config_test;
    logic clk_sys, rst_b, regWrEn, regRdEn, sampleStrobe, playbackMasterPower;
    logic                  customCoefLoaded, regRdValid, customIirOn, customIirAllPass;
    logic                  biquadsBypassed, powerChangeRefused;
    logic [7:0]            regAddr, regWrData, regRdData;
    logic [3:0]            chanMuted, chanPowered;
    pdc_pkg::pdc_vol_vec_t digitalVolume, appliedVolume;
    pdc_pkg::pdc_dsp_cfg_t dspCfg;
    int                    failures = 0;
    int                    checks_done = 0;
    int                    cycleCount = 0;

    pdc_channel_config uut (.clk_sys(clk_sys), .rst_b(rst_b), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .sampleStrobe(sampleStrobe),
        .playbackMasterPower(playbackMasterPower), .customCoefLoaded(customCoefLoaded),
        .digitalVolume(digitalVolume), .dspCfg(dspCfg), .customIirOn(customIirOn),
        .customIirAllPass(customIirAllPass), .biquadsBypassed(biquadsBypassed),
        .appliedVolume(appliedVolume), .chanMuted(chanMuted), .chanPowered(chanPowered),
        .powerChangeRefused(powerChangeRefused));

    // Free-running 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Hang guard, far above the roughly 90 cycles the tests need
    always @(posedge clk_sys) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 3000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Bus helpers, each returns at a falling edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        regWrEn = 1'b1;
        regAddr = addr;
        regWrData = data;
        @(negedge clk_sys);
        regWrEn = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk_sys);
        regRdEn = 1'b1;
        regAddr = addr;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        chk(regRdValid, 1'b1);
        chk(regRdData, exp);
    endtask

    task automatic strobe();
        @(negedge clk_sys);
        sampleStrobe = 1'b1;
        @(negedge clk_sys);
        sampleStrobe = 1'b0;
    endtask

    task automatic t_reset();
        rd_chk(8'h73, 8'h18);
        rd_chk(8'h76, 8'hCC);
        rd_chk(8'h77, 8'h00);
        wr(8'h74, 8'hFF);
        rd_chk(8'h74, 8'h00);
        chk(dspCfg, 8'h1A);
        chk(appliedVolume, {4{8'hC9}});
        chk(chanPowered, 4'h0);
        $display("reset values done");
    endtask

    // Every code of each filter field but the gang bit, with the reserved interp code last
    task automatic t_filters();
        logic [1:0] c;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            v = {c, c, ~c, c[0], 1'b0};
            wr(8'h73, v);
            chk(dspCfg.highpassCornerSel, (i == 0) ? 2'h1 : c - 2'h1);
            strobe();
            chk(dspCfg, {(c == 2'h3) ? 2'h2 : c, c, ~c, ~c[0], 1'b0});
            chk(customIirAllPass, i == 0);
            chk(biquadsBypassed, i == 3);
            rd_chk(8'h73, v);
        end
        wr(8'h73, 8'h0C);
        strobe();
        customCoefLoaded = 1'b1;
        #5;
        chk({customIirOn, customIirAllPass}, 2'h2);
        $display("filter codes done");
    endtask

    task automatic t_volume();
        digitalVolume = {8'h10, 8'h00, 8'hFF, 8'h01};
        wr(8'h73, 8'h18);
        strobe();
        chk(appliedVolume, 32'h1000FF01);
        chk(chanMuted, 4'h4);
        wr(8'h73, 8'h19);
        chk(appliedVolume, 32'h1000FF01);
        strobe();
        chk(appliedVolume, {4{8'h10}});
        digitalVolume[3] = 8'h00;
        strobe();
        chk(chanMuted, 4'hF);
        $display("volume done");
    endtask

    // Reserved enable bits are always written back with their reset values
    task automatic t_power();
        playbackMasterPower = 1'b1;
        strobe();
        chk(chanPowered, 4'hC);
        wr(8'h76, 8'hCE);
        strobe();
        chk({powerChangeRefused, chanPowered}, 5'h1C);
        wr(8'h77, 8'h20);
        strobe();
        chk(chanPowered, 4'hC);
        wr(8'h77, 8'hFF);
        rd_chk(8'h77, 8'hF8);
        strobe();
        chk({powerChangeRefused, chanPowered}, 5'h0E);
        playbackMasterPower = 1'b0;
        strobe();
        chk(chanPowered, 4'h0);
        rst_b = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        rd_chk(8'h77, 8'h00);
        chk(dspCfg, 8'h1A);
        $display("power done");
    endtask

    initial begin
        rst_b = 1'b0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        sampleStrobe = 1'b0;
        playbackMasterPower = 1'b0;
        customCoefLoaded = 1'b0;
        digitalVolume = {4{8'hC9}};
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        t_reset();
        t_filters();
        t_volume();
        t_power();
        wrap_up();
    end
endmodule
